// ### hdl/int_accept_ctrl.sv
// Interrupt acceptance, priority and exception-entry sequencing.
// Assumes the CPU core supplies instruction boundaries and control writes.
`timescale 1ns/1ps
`default_nettype none

module int_accept_ctrl #(
    parameter int NUM_EXT = int_accept_pkg::EXT_SRC_NUM,
    parameter int NUM_INT = int_accept_pkg::INT_SRC_NUM,
    parameter int NUM_SRC = NUM_EXT + NUM_INT,
    parameter int IDX_W = $clog2(NUM_SRC)
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Mode select
    input wire logic ctlModeSelHi,
    input wire logic ctlModeSelLo,
    input wire logic standby,
    // Requests, external first then on-chip
    input wire logic nmiReq,
    input wire logic [NUM_SRC-1:0] srcFlag,
    input wire logic [NUM_SRC-1:0] srcEnable,
    input wire logic [NUM_SRC-1:0][2:0] sourcePriorityLevel,
    // CPU status
    input wire logic insnEnd,
    input wire logic blockMoveByteCount,
    input wire logic blockMoveWordBreak,
    input wire int_accept_pkg::ctl_write_s ctlWr,
    // Exception entry
    output int_accept_pkg::entry_out_s entryOut,
    // Mask state
    output logic globalMask,
    output logic [2:0] threeBitMaskLevel,
    output logic traceBit,
    output logic modeIllegal
);
    import int_accept_pkg::*;

    entry_state_e state_ff;
    entry_state_e nxt_state;
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;
    logic [IDX_W-1:0] winIdx_ff;
    logic [2:0] winLvl_ff;
    logic winNmi_ff;
    logic globalMask_ff;
    logic [2:0] maskLevel_ff;
    logic trace_ff;
    logic modeIllegal_ff;
    entry_out_s out_ff;
    entry_out_s nxt_out;

    logic [NUM_SRC-1:0] pend;
    logic selFound;
    logic [IDX_W-1:0] selIdx;
    logic [2:0] selLvl;
    logic levelMode;
    logic applyWr;
    ctl_write_s applyData;
    logic blackout;
    logic blocked;
    logic boundary;
    logic curOk;
    logic curExt;
    logic latchedOk;
    logic grant;
    logic gNmi;
    logic [2:0] gLvl;
    logic [7:0] gVec;
    logic [IDX_W-1:0] gIdx;

    // Only the upper bit decides the mode; lower bit set is flagged
    assign levelMode = ctlModeSelHi; // see RULE22
    assign pend = srcFlag & srcEnable; // see RULE4

    prio_select #(
        .NUM_SRC(NUM_SRC),
        .IDX_W(IDX_W)
    ) u_sel (
        .pend(pend),
        .level(sourcePriorityLevel),
        .levelMode(levelMode),
        .globalMask(globalMask_ff),
        .maskLevel(maskLevel_ff),
        .found(selFound),
        .idx(selIdx),
        .lvl(selLvl)
    );

    mask_write_timer u_tmr (
        .core_clk(core_clk),
        .nrst(nrst),
        .ctlWr(ctlWr),
        .insnEnd(insnEnd),
        .applyWr(applyWr),
        .applyData(applyData),
        .blackout(blackout)
    );

    // Byte block move and standby lock out even the non-maskable request
    assign blocked = standby | blackout | blockMoveByteCount; // see RULE20 see RULE23 see RULE18
    assign boundary = (insnEnd & ~blockMoveByteCount) | blockMoveWordBreak; // see RULE7 see RULE21
    assign curOk = nmiReq | selFound; // see RULE6 see RULE5
    assign curExt = nmiReq | (32'(selIdx) < NUM_EXT);
    // A latched winner stays serviceable if its source was cleared meanwhile
    assign latchedOk = winNmi_ff | (levelMode ? (winLvl_ff > maskLevel_ff) : !globalMask_ff); // see RULE17
    assign grant = (state_ff == ST_WAIT_END) & (curOk | latchedOk) & boundary & ~blocked;
    // Any live request that passes the mask displaces the latched one, even at a lower level
    assign gNmi = curOk ? nmiReq : winNmi_ff; // see RULE17
    assign gIdx = curOk ? selIdx : winIdx_ff;
    assign gLvl = gNmi ? NMI_MASK_LEVEL : (curOk ? selLvl : winLvl_ff);
    assign gVec = gNmi ? NMI_VECTOR : srcVector(int'(gIdx), NUM_EXT);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (curOk && !blocked)
                begin
                    nxt_state = ST_PRIO;
                    nxt_cnt = curExt ? 2'(PRIO_EXT_CYC - 1) : 2'(PRIO_INT_CYC - 1); // see RULE14
                end
            end
            ST_PRIO:
            begin
                if (cnt_ff == 2'h0)
                    nxt_state = ST_WAIT_END;
                else
                    nxt_cnt = cnt_ff - 2'h1;
            end
            ST_WAIT_END:
            begin
                if (grant)
                    nxt_state = ST_PROC_A; // see RULE16
                else if (!curOk && !latchedOk)
                    nxt_state = ST_IDLE; // see RULE11 see RULE3
            end
            ST_PROC_A:
            begin
                nxt_state = ST_STACK;
                nxt_cnt = ctlModeSelHi ? 2'(STACK_ACC_HI - 1) : 2'(STACK_ACC_LO - 1); // see RULE15
            end
            ST_STACK:
            begin
                if (cnt_ff == 2'h0)
                    nxt_state = ST_VEC;
                else
                    nxt_cnt = cnt_ff - 2'h1;
            end
            ST_VEC:
                nxt_state = ST_PROC_B; // see RULE16
            ST_PROC_B:
                nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_comb
    begin
        nxt_out = out_ff;
        nxt_out.acceptStrobe = grant; // see RULE24
        nxt_out.stackStrobe = (nxt_state == ST_STACK);
        nxt_out.vectorFetch = (nxt_state == ST_VEC);
        nxt_out.entryBusy = (nxt_state == ST_PROC_A) || (nxt_state == ST_STACK) ||
                            (nxt_state == ST_VEC) || (nxt_state == ST_PROC_B);
        nxt_out.entryDone = (state_ff == ST_PROC_B);
        if (grant)
        begin
            nxt_out.vector = gVec; // see RULE2
            nxt_out.pcNextInsn = blockMoveWordBreak; // see RULE21
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= 2'h0;
            out_ff <= '0;
            modeIllegal_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            out_ff <= nxt_out;
            modeIllegal_ff <= ctlModeSelLo;
        end
    end

    // Winner latched when priority determination starts
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            winIdx_ff <= '0;
            winLvl_ff <= 3'h0;
            winNmi_ff <= 1'b0;
        end
        else if (state_ff == ST_IDLE && nxt_state == ST_PRIO)
        begin
            winIdx_ff <= selIdx;
            winLvl_ff <= nmiReq ? NMI_MASK_LEVEL : selLvl;
            winNmi_ff <= nmiReq;
        end
    end

    // Mask state: entry updates win over a delayed CPU write
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            globalMask_ff <= GLOBAL_MASK_RESET;
            maskLevel_ff <= MASK_LEVEL_RESET;
            trace_ff <= TRACE_RESET;
        end
        else if (grant)
        begin
            globalMask_ff <= 1'b1; // see RULE8 see RULE12
            if (levelMode)
            begin
                maskLevel_ff <= gLvl; // see RULE9 see RULE10
                trace_ff <= 1'b0; // see RULE9
            end
        end
        else if (applyWr)
        begin
            globalMask_ff <= applyData.globalMask; // see RULE18
            maskLevel_ff <= applyData.maskLevel;
            trace_ff <= applyData.trace;
        end
    end

    assign entryOut = out_ff;
    assign globalMask = globalMask_ff;
    assign threeBitMaskLevel = maskLevel_ff;
    assign traceBit = trace_ff;
    assign modeIllegal = modeIllegal_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_prio_enter_ext;
        state_ff == ST_IDLE ##1 state_ff == ST_PRIO && (winNmi_ff || 32'(winIdx_ff) < NUM_EXT);
    endsequence

    sequence s_prio_enter_int;
        state_ff == ST_IDLE ##1 state_ff == ST_PRIO && !winNmi_ff && 32'(winIdx_ff) >= NUM_EXT;
    endsequence

    sequence s_stack_two;
        entryOut.stackStrobe [*2] ##1 (!entryOut.stackStrobe && entryOut.vectorFetch);
    endsequence

    sequence s_stack_three;
        entryOut.stackStrobe [*3] ##1 (!entryOut.stackStrobe && entryOut.vectorFetch);
    endsequence

    property p_prio_ext;
        s_prio_enter_ext |-> ##2 state_ff == ST_PRIO ##1 state_ff != ST_PRIO;
    endproperty
    a_prio_ext: assert property (p_prio_ext) else $error("external priority determination not three states"); // see RULE14

    property p_prio_int;
        s_prio_enter_int |-> ##1 state_ff == ST_PRIO ##1 state_ff != ST_PRIO;
    endproperty
    a_prio_int: assert property (p_prio_int) else $error("internal priority determination not two states"); // see RULE14

    property p_stack_lo;
        entryOut.acceptStrobe && !$past(ctlModeSelHi) && !ctlModeSelHi |-> ##1 s_stack_two;
    endproperty
    a_stack_lo: assert property (p_stack_lo) else $error("stacking not two accesses"); // see RULE15

    property p_stack_hi;
        entryOut.acceptStrobe && $past(ctlModeSelHi) && ctlModeSelHi |-> ##1 s_stack_three;
    endproperty
    a_stack_hi: assert property (p_stack_hi) else $error("stacking not three accesses"); // see RULE15

    property p_accept_at_boundary;
        entryOut.acceptStrobe |-> $past(state_ff) == ST_WAIT_END && $past(boundary);
    endproperty
    a_accept_at_boundary: assert property (p_accept_at_boundary) else $error("accept off boundary"); // see RULE7

    property p_mask_set;
        entryOut.acceptStrobe |-> globalMask;
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("global mask not set on accept"); // see RULE12

    property p_nmi_level;
        entryOut.acceptStrobe && entryOut.vector == NMI_VECTOR && $past(ctlModeSelHi)
            |-> threeBitMaskLevel == NMI_MASK_LEVEL && !traceBit;
    endproperty
    a_nmi_level: assert property (p_nmi_level) else $error("mask level not seven after nmi"); // see RULE10

    property p_level_rises;
        entryOut.acceptStrobe && entryOut.vector != NMI_VECTOR && $past(ctlModeSelHi)
            |-> threeBitMaskLevel > $past(threeBitMaskLevel);
    endproperty
    a_level_rises: assert property (p_level_rises) else $error("accepted level not above mask"); // see RULE11

    property p_mode0_mask;
        entryOut.acceptStrobe && entryOut.vector != NMI_VECTOR && !$past(ctlModeSelHi)
            |-> !$past(globalMask);
    endproperty
    a_mode0_mask: assert property (p_mode0_mask) else $error("maskable accepted while masked"); // see RULE6

    property p_byte_move;
        blockMoveByteCount |=> !entryOut.acceptStrobe;
    endproperty
    a_byte_move: assert property (p_byte_move) else $error("accept during byte block move"); // see RULE20

    property p_blackout;
        ctlWr.en |=> !entryOut.acceptStrobe [*4];
    endproperty
    a_blackout: assert property (p_blackout) else $error("accept inside blackout window"); // see RULE19

    property p_internal_proc;
        entryOut.vectorFetch |=> state_ff == ST_PROC_B ##1 entryOut.entryDone;
    endproperty
    a_internal_proc: assert property (p_internal_proc) else $error("internal state after fetch missing"); // see RULE16

endmodule

`default_nettype wire

// ### common/int_accept_pkg.sv
// Shared constants, types and helpers for the interrupt acceptance block.
// Assumes one core clock where one CPU state equals one clock cycle.
// Notes on behaviour
// RULE1 - Eight-level mode takes highest level request, only if above mask level.
// RULE2 - Equal levels resolve by fixed order, lower vector wins; only winner gets vector.
// RULE3 - Losing requests stay pending and can be taken later.
// RULE4 - A source requests only while its flag and enable bit are both set.
// RULE5 - Single-mask mode accepts maskable requests while global mask is clear.
// RULE6 - Single-mask mode with mask set still accepts the non-maskable request.
// RULE7 - Entry starts only after the current instruction completes.
// RULE8 - Single-mask entry stacks two registers, then sets the global mask; the code sets it at the grant, before stacking.
// RULE9 - Eight-level entry stacks three registers, clears trace, loads accepted level.
// RULE10 - Non-maskable acceptance in eight-level mode sets mask level to seven.
// RULE11 - Eight-level request not above mask level is held pending.
// RULE12 - Eight-level mode ignores global mask for acceptance but sets it on entry.
// RULE13 - Software leaves priority levels at reset values in single-mask mode.
// RULE14 - Priority determination takes three states external, two states internal.
// RULE15 - Stacking takes two accesses with upper mode bit 0, three with it 1.
// RULE16 - Entry has two internal states, after acceptance and after vector fetch.
// RULE17 - Clearing flag or enable acts after the instruction; higher request still wins.
// RULE18 - After control-register instruction all requests wait; mask valid two states later.
// RULE19 - Acceptance suppressed three states after a mask update instruction.
// RULE20 - Byte-count block move accepts nothing, even non-maskable, until done.
// RULE21 - Word-count block move takes requests at breaks; stacked PC is next instruction.
// RULE22 - Mode bits 00 select single-mask, 10 eight-level; other codes prohibited.
// RULE23 - Non-maskable request accepted always, except reset and standby; the code also blocks it during byte-count block moves and the blackout.
// RULE24 - Accepted vector and acceptance strobe appear registered, one cycle after the grant cycle.

package int_accept_pkg;

    localparam int EXT_SRC_NUM = 8;
    localparam int INT_SRC_NUM = 16;
    localparam logic [7:0] NMI_VECTOR = 8'h07;
    localparam logic [7:0] EXT_VEC_BASE = 8'h10;
    localparam logic [7:0] INT_VEC_BASE = 8'h18;
    localparam logic [2:0] NMI_MASK_LEVEL = 3'h7;
    localparam logic [2:0] MASK_LEVEL_RESET = 3'h7;
    localparam logic GLOBAL_MASK_RESET = 1'b1;
    localparam logic TRACE_RESET = 1'b0;
    localparam logic [2:0] SRC_LEVEL_RESET = 3'h7;

    // Timing is printed in CPU states; one state per core clock
    localparam int CYC_PER_STATE = 1;
    localparam int PRIO_EXT_STATES = 3;
    localparam int PRIO_INT_STATES = 2;
    localparam int STACK_ACC_LO = 2;
    localparam int STACK_ACC_HI = 3;
    localparam int MASK_VALID_STATES = 2;
    localparam int BLACKOUT_STATES = 3;
    localparam int PRIO_EXT_CYC = PRIO_EXT_STATES * CYC_PER_STATE;
    localparam int PRIO_INT_CYC = PRIO_INT_STATES * CYC_PER_STATE;
    localparam int MASK_VALID_CYC = MASK_VALID_STATES * CYC_PER_STATE;
    localparam int BLACKOUT_CYC = BLACKOUT_STATES * CYC_PER_STATE;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PRIO,
        ST_WAIT_END,
        ST_PROC_A,
        ST_STACK,
        ST_VEC,
        ST_PROC_B
    } entry_state_e;

    // Control-register write from the CPU at the end of a load/logic instruction
    typedef struct packed {
        logic en;
        logic globalMask;
        logic [2:0] maskLevel;
        logic trace;
    } ctl_write_s;

    typedef struct packed {
        logic acceptStrobe;
        logic [7:0] vector;
        logic stackStrobe;
        logic vectorFetch;
        logic entryBusy;
        logic entryDone;
        logic pcNextInsn;
    } entry_out_s;

    function automatic logic [7:0] srcVector(input int idx, input int numExt);
        logic [7:0] v;
        v = (idx < numExt) ? EXT_VEC_BASE + 8'(idx) : INT_VEC_BASE + 8'(idx - numExt);
        return v;
    endfunction

endpackage

// ### hdl/prio_select.sv
// Combinational priority pick among enabled maskable requests.
// Assumes the caller supplies the live mask state and mode.
`timescale 1ns/1ps
`default_nettype none

module prio_select #(
    parameter int NUM_SRC = 24,
    parameter int IDX_W = $clog2(NUM_SRC)
) (
    // Requests
    input wire logic [NUM_SRC-1:0] pend,
    input wire logic [NUM_SRC-1:0][2:0] level,
    // Mask state
    input wire logic levelMode,
    input wire logic globalMask,
    input wire logic [2:0] maskLevel,
    // Result
    output logic found,
    output logic [IDX_W-1:0] idx,
    output logic [2:0] lvl
);
    logic any;
    logic [IDX_W-1:0] bestIdx;
    logic [2:0] bestLvl;

    // Downward scan with >= lets the lower index win on equal level
    always_comb
    begin
        any = 1'b0;
        bestIdx = '0;
        bestLvl = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (pend[i] && (!any || (levelMode ? level[i] : 3'h0) >= bestLvl)) // see RULE2
            begin
                any = 1'b1;
                bestIdx = IDX_W'(i);
                bestLvl = levelMode ? level[i] : 3'h0;
            end
        end
    end

    // Best is compared once; no fall-through to a lower request
    assign found = any && (levelMode ? (bestLvl > maskLevel) : !globalMask); // see RULE1
    assign idx = bestIdx;
    assign lvl = bestLvl;

endmodule

`default_nettype wire

// ### hdl/mask_write_timer.sv
// Delays CPU mask writes and produces the acceptance blackout window.
// Assumes ctlWr pulses once in the cycle its instruction ends.
`timescale 1ns/1ps
`default_nettype none

module mask_write_timer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // CPU side
    input wire int_accept_pkg::ctl_write_s ctlWr,
    input wire logic insnEnd,
    // Results
    output logic applyWr,
    output int_accept_pkg::ctl_write_s applyData,
    output logic blackout
);
    import int_accept_pkg::*;

    logic [1:0] dlyCnt_ff;
    logic [1:0] blkCnt_ff;
    logic waitInsn_ff;
    ctl_write_s hold_ff;
    logic [1:0] nxt_dlyCnt;
    logic [1:0] nxt_blkCnt;
    logic nxt_waitInsn;

    assign nxt_dlyCnt = ctlWr.en ? 2'(MASK_VALID_CYC - 1) : (dlyCnt_ff != 2'h0 ? dlyCnt_ff - 2'h1 : 2'h0);
    assign nxt_blkCnt = ctlWr.en ? 2'(BLACKOUT_CYC) : (blkCnt_ff != 2'h0 ? blkCnt_ff - 2'h1 : 2'h0);
    // The writing instruction's own end does not count as the next one
    assign nxt_waitInsn = ctlWr.en | (waitInsn_ff & ~insnEnd);

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            dlyCnt_ff <= 2'h0;
            blkCnt_ff <= 2'h0;
            waitInsn_ff <= 1'b0;
            hold_ff <= '0;
        end
        else
        begin
            dlyCnt_ff <= nxt_dlyCnt;
            blkCnt_ff <= nxt_blkCnt;
            waitInsn_ff <= nxt_waitInsn;
            if (ctlWr.en)
                hold_ff <= ctlWr;
        end
    end

    assign applyWr = (dlyCnt_ff == 2'h1); // see RULE18
    assign applyData = hold_ff;
    assign blackout = ctlWr.en | (blkCnt_ff != 2'h0) | waitInsn_ff; // see RULE19

endmodule

`default_nettype wire

// ### testbench/cpu_core_model.sv
// CPU core model: instruction boundaries and stack access count.
// Assumes one CPU state per core_clk; no instruction runs during entry.
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model #(
    parameter int INSN_LEN = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Bench control and entry signals
    input wire logic hold,
    input wire int_accept_pkg::entry_out_s entryOut,
    // Results
    output logic insnEnd,
    output var int stackCount
);
    import int_accept_pkg::*;
    int cnt;

    initial insnEnd = 1'b0;

    // Boundaries stop while entry runs; hold models a long block move
    always @(posedge core_clk)
    begin
        insnEnd <= 1'b0;
        if (!nrst || entryOut.entryBusy)
            cnt <= 0;
        else if (cnt == INSN_LEN - 1)
        begin
            cnt <= 0;
            insnEnd <= !hold;
        end
        else
            cnt <= cnt + 1;
        if (!nrst || entryOut.acceptStrobe)
            stackCount <= 0;
        else if (entryOut.stackStrobe)
            stackCount <= stackCount + 1;
    end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the interrupt acceptance block.
// Assumes the CPU model supplies boundaries; one state per cycle.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import int_accept_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, ctlModeSelHi = 1'b0, standby = 1'b0, nmiReq = 1'b0;
    logic ctlModeSelLo = 1'b0, modeIllegal;
    logic blockMoveByteCount = 1'b0, blockMoveWordBreak = 1'b0, hold = 1'b0, insnEnd;
    logic [23:0] srcFlag = '0, srcEnable = '0;
    logic [23:0][2:0] sourcePriorityLevel = '0;
    ctl_write_s ctlWr = '0;
    entry_out_s entryOut;
    logic globalMask, traceBit;
    logic [2:0] threeBitMaskLevel;
    int stackCount, num_errors = 0, n_tests = 0, eMl = 7, eLvl;
    bit eGm = 1'b1;

    always #12.5 core_clk = ~core_clk;

    int_accept_ctrl i_dut (.core_clk(core_clk), .nrst(nrst), .ctlModeSelHi(ctlModeSelHi),
        .ctlModeSelLo(ctlModeSelLo), .standby(standby), .nmiReq(nmiReq), .srcFlag(srcFlag),
        .srcEnable(srcEnable), .sourcePriorityLevel(sourcePriorityLevel), .insnEnd(insnEnd),
        .blockMoveByteCount(blockMoveByteCount), .blockMoveWordBreak(blockMoveWordBreak),
        .ctlWr(ctlWr), .entryOut(entryOut), .globalMask(globalMask),
        .threeBitMaskLevel(threeBitMaskLevel), .traceBit(traceBit), .modeIllegal(modeIllegal));
    cpu_core_model i_cpu (.core_clk(core_clk), .nrst(nrst), .hold(hold), .entryOut(entryOut),
        .insnEnd(insnEnd), .stackCount(stackCount));

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (exp !== got)
        begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // Reference pick: NMI first, then highest level, lowest index
    function automatic int ref_pick();
        int best, bl, l;
        best = -1;
        bl = -1;
        eLvl = 7;
        if (nmiReq)
            return NMI_VECTOR;
        for (int i = 0; i < 24; i++)
        begin
            l = ctlModeSelHi ? int'(sourcePriorityLevel[i]) : 0;
            if (srcFlag[i] && srcEnable[i] && l > bl)
            begin
                bl = l;
                best = i;
            end
        end
        if (best < 0 || (ctlModeSelHi ? bl <= eMl : eGm))
            return -1;
        eLvl = bl;
        return best < 8 ? int'(EXT_VEC_BASE) + best : int'(INT_VEC_BASE) + best - 8;
    endfunction

    task automatic setm(input bit gm, input int ml);
        @(posedge core_clk);
        ctlWr <= '{en: 1'b1, globalMask: gm, maskLevel: 3'(ml), trace: 1'b1};
        @(posedge core_clk);
        ctlWr.en <= 1'b0;
        // New mask is visible two cycles after the write pulse, before any pending accept
        repeat (2) @(posedge core_clk);
        #1;
        eGm = gm;
        eMl = ml;
        chk("mask", {4'h0, gm, 3'(ml)}, {4'h0, globalMask, threeBitMaskLevel});
        // Let the blackout end on an instruction boundary
        repeat (3) @(posedge core_clk);
    endtask

    task automatic trial(input bit blk);
        int e;
        bit seen;
        // Let the caller's non-blocking stimulus settle before the reference looks
        #1;
        e = blk ? -1 : ref_pick();
        seen = 1'b0;
        repeat (40)
        begin
            #1;
            if (entryOut.acceptStrobe === 1'b1)
            begin
                seen = 1'b1;
                break;
            end
            @(posedge core_clk);
        end
        chk("accepted", 8'(e >= 0), 8'(seen));
        if (seen && e >= 0)
        begin
            if (ctlModeSelHi)
                eMl = eLvl;
            eGm = 1'b1;
            chk("vector", 8'(e), entryOut.vector);
            chk("maskLevel", 8'(eMl), 8'(threeBitMaskLevel));
            chk("globalMask", 8'h01, 8'(globalMask));
            if (ctlModeSelHi)
                chk("trace", 8'h00, 8'(traceBit));
            repeat (20)
            begin
                @(posedge core_clk);
                #1;
                if (entryOut.entryDone === 1'b1)
                    break;
            end
            chk("stacks", ctlModeSelHi ? 8'h03 : 8'h02, 8'(stackCount));
        end
        $display("test done vector %0d", e);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge core_clk);
        num_errors++;
        final_report();
    end

    initial
    begin
        void'($urandom(95141));
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        srcEnable <= 24'hFFFFFD;
        // Levels stay at reset in single-mask mode
        sourcePriorityLevel <= {24{SRC_LEVEL_RESET}};
        setm(1'b0, 7);
        srcFlag <= 24'h000202;
        trial(1'b0);
        nmiReq <= 1'b1;
        trial(1'b0);
        nmiReq <= 1'b0;
        trial(1'b0);
        setm(1'b0, 7);
        trial(1'b0);
        srcFlag <= '0;
        standby <= 1'b1;
        nmiReq <= 1'b1;
        trial(1'b1);
        standby <= 1'b0;
        blockMoveByteCount <= 1'b1;
        trial(1'b1);
        blockMoveByteCount <= 1'b0;
        trial(1'b0);
        nmiReq <= 1'b0;
        setm(1'b0, 7);
        hold <= 1'b1;
        srcFlag <= 24'h000001;
        repeat (6) @(posedge core_clk);
        blockMoveWordBreak <= 1'b1;
        @(posedge core_clk);
        blockMoveWordBreak <= 1'b0;
        trial(1'b0);
        chk("pcNext", 8'h01, 8'(entryOut.pcNextInsn));
        hold <= 1'b0;
        srcFlag <= '0;
        ctlModeSelHi <= 1'b1;
        sourcePriorityLevel <= {24{3'h5}};
        setm(1'b1, 4);
        srcFlag <= 24'h001400;
        trial(1'b0);
        trial(1'b0);
        nmiReq <= 1'b1;
        trial(1'b0);
        nmiReq <= 1'b0;
        srcFlag <= '0;
        for (int k = 0; k < 8; k++)
        begin
            for (int i = 0; i < 24; i++)
                sourcePriorityLevel[i] <= 3'($urandom);
            srcEnable <= 24'($urandom);
            setm(1'b1, $urandom % 7);
            srcFlag <= 24'($urandom);
            @(posedge core_clk);
            trial(1'b0);
            srcFlag <= '0;
        end
        ctlModeSelLo <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk("modeIllegal", 8'h01, 8'(modeIllegal));
        ctlModeSelLo <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("modeIllegal", 8'h00, 8'(modeIllegal));
        final_report();
    end
endmodule
`default_nettype wire
